// File: logic/otp_word_decode.sv
// single-error-correcting decoder for one 12-bit storage word
// assumes the word is read combinationally from storage on the same clock
module otp_word_decode (
	input  wire logic [11:0] code,      // codeword, bit i is position i+1
	output logic      [7:0]  data,      // corrected data byte
	output logic             corrected  // a single bit was repaired
);
	logic [3:0]  syn;
	logic [11:0] fixed;

	always_comb begin
		syn = 4'h0;
		for (int p = 1; p <= 12; p++) begin
			if (code[p-1])
				syn = syn ^ 4'(p);
		end
		fixed = code;
		corrected = 1'b0;
		if (syn != 4'h0 && syn <= 4'hc) begin
			fixed[syn - 4'h1] = ~code[syn - 4'h1];
			corrected = 1'b1;
		end
		data = {fixed[11], fixed[10], fixed[9], fixed[8], fixed[6], fixed[5], fixed[4], fixed[2]};
	end
endmodule

// File: logic/reset_fault_control.sv
// reset pin control, fault routing, watchdog register protection and config reload
// assumes watchdog pulses and the register port come from logic on clk;
// pins and comparator outputs are asynchronous and are synchronised here
// What this block does
// - protect bit blocks watchdog writes except key, protect
// - select clear: reset on every watchdog violation
// - select set: two consecutive violations; refresh clears count
// - hold reset 8, 16 or 32 ms
// - hold code zero gives about 6 us pulse
// - read-only eight-bit factory variant code
// - enable zero falling edge reloads after recorder finishes
// - reload leaves timestamps untouched
// - optional reload on watchdog fault
// - reload completes in about 1 us
// - stored configuration corrected for single-bit errors
// - fault register shows parity, clock, pins, self-test
// - host reads reset pin level
// - host reads both enable input levels
// - clock stuck or slow asserts reset
// - register parity error asserts reset
// - comparator stuck asserts reset, sets flag
// - rail high, low or off asserts reset
// - supply lockout asserts reset
// - early refresh or window expiry are violations
module reset_fault_control #(
	parameter int unsigned CHANNELS      = 7,
	parameter int unsigned HOLD_8MS_CYC  = reset_fault_pkg::HOLD_8MS_CYC,
	parameter int unsigned HOLD_16MS_CYC = reset_fault_pkg::HOLD_16MS_CYC,
	parameter int unsigned HOLD_32MS_CYC = reset_fault_pkg::HOLD_32MS_CYC
) (
	input  wire logic                clk,           // 125 MHz
	input  wire logic                sys_rst,       // synchronous, active high
	input  wire logic                reg_wr,        // register write strobe
	input  wire logic                reg_rd,        // register read strobe
	input  wire logic [7:0]          reg_addr,      // register offset
	input  wire logic [7:0]          reg_wdata,     // write data
	output logic      [7:0]          reg_rdata,     // read data, cycle after reg_rd
	output logic                     wd_key_wr,     // key register write to watchdog
	output logic      [7:0]          wd_cdiv,       // watchdog divider register
	output logic      [7:0]          wd_cfg1,       // watchdog window register
	output logic      [7:0]          wd_cfg2,       // watchdog enable register
	input  wire logic                wd_early,      // pulse: refresh in closed window
	input  wire logic                wd_expired,    // pulse: open window expired
	input  wire logic                wd_refresh_ok, // pulse: valid refresh
	input  wire logic [CHANNELS-1:0] rail_ov,       // rail too high
	input  wire logic [CHANNELS-1:0] rail_uv,       // rail too low
	input  wire logic [CHANNELS-1:0] rail_off,      // rail shut down
	input  wire logic [CHANNELS-1:0] comp_stuck,    // comparator diagnostic failed
	input  wire logic                uvlo,          // supply lockout tripped
	input  wire logic                bist_fail,     // self-test result
	input  wire logic                recorder_done, // sequence recorder finished
	input  wire logic                en0_pin,       // enable input zero
	input  wire logic                en1_pin,       // enable input one
	input  wire logic                osc_mon_pin,   // system clock under check
	input  wire logic                rst_pin_in,    // reset pin readback
	output logic                     rst_pin_out,   // reset pin drive level
	output logic                     rst_pin_oe_n,  // low while reset pin pulled low
	output logic      [2:0]          otp_index,     // storage word address
	input  wire logic [11:0]         otp_code,      // storage word with check bits
	output logic                     load_busy      // configuration load running
);
	localparam int SW = 4 * CHANNELS + 5;

	logic [SW-1:0] sync1_reg, sync2_reg;
	logic [CHANNELS-1:0] ov_s, uv_s, off_s, stuck_s;
	logic uvlo_s, en0_s, en1_s, osc_s, rstpin_s;
	logic en0_d_reg, osc_d_reg;
	logic [7:0] clk_cnt_reg;
	logic clk_fault_reg;
	logic viol, viol_cnt_reg, wd_rst_reg;
	logic diag_flag_reg;
	logic lock_reg, lock_next, reload_cfg_reg, reload_cfg_next;
	logic [2:0] reset_output_control_reg, reset_output_control_next;
	logic [7:0] cdiv_next, cfg1_next, cfg2_next, variant_reg, variant_next;
	logic parity_reg, parity_fault;
	logic [7:0] otp_data;
	reset_fault_pkg::load_state_t ld_state_reg;
	logic [7:0] step_cnt_reg;
	logic [2:0] idx_reg;
	logic por_pend_reg, wd_pend_reg, en0_pend_reg;
	logic take_run, take_en0, word_load, bus_wr_ok;
	logic cause, rst_active_reg;
	logic [reset_fault_pkg::HOLD_W-1:0] hold_cnt_reg, hold_target;

	// two-flop synchronisers for every asynchronous input
	always_ff @(posedge clk) begin
		sync1_reg <= {rail_ov, rail_uv, rail_off, comp_stuck,
			uvlo, en0_pin, en1_pin, osc_mon_pin, rst_pin_in};
		sync2_reg <= sync1_reg;
	end
	assign {ov_s, uv_s, off_s, stuck_s, uvlo_s, en0_s, en1_s, osc_s, rstpin_s} = sync2_reg;

	// clock check: no rising edge for too long covers stuck high, stuck low and slow
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			osc_d_reg <= 1'b0;
			clk_cnt_reg <= 8'h00;
			clk_fault_reg <= 1'b0;
		end else begin
			osc_d_reg <= osc_s;
			if (osc_s && !osc_d_reg)
				clk_cnt_reg <= 8'h00;
			else if (clk_cnt_reg != 8'(reset_fault_pkg::CLK_CHECK_CYC))
				clk_cnt_reg <= clk_cnt_reg + 8'h01;
			clk_fault_reg <= (clk_cnt_reg == 8'(reset_fault_pkg::CLK_CHECK_CYC));
		end
	end

	// watchdog violation counting
	assign viol = wd_early | wd_expired;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			viol_cnt_reg <= 1'b0;
			wd_rst_reg <= 1'b0;
		end else begin
			wd_rst_reg <= 1'b0;
			if (viol) begin
				if (!reset_output_control_reg[reset_fault_pkg::DBL_BIT] || viol_cnt_reg) begin
					wd_rst_reg <= 1'b1;
					viol_cnt_reg <= 1'b0;
				end else begin
					viol_cnt_reg <= 1'b1;
				end
			end else if (wd_refresh_ok) begin
				viol_cnt_reg <= 1'b0;
			end
		end
	end

	// comparator diagnostic flag, set wins over a host clear
	always_ff @(posedge clk) begin
		if (sys_rst)
			diag_flag_reg <= 1'b0;
		else if (|stuck_s)
			diag_flag_reg <= 1'b1;
		else if (bus_wr_ok && reg_addr == reset_fault_pkg::ADDR_FAULT
			&& reg_wdata[reset_fault_pkg::FLT_DIAG])
			diag_flag_reg <= 1'b0;
	end

	// configuration registers: a load from storage beats a host write
	assign bus_wr_ok = reg_wr && !load_busy;
	assign wd_key_wr = reg_wr && reg_addr == reset_fault_pkg::ADDR_KEY;
	otp_word_decode u_decode (
		.code      (otp_code),
		.data      (otp_data),
		.corrected ()
	);

	always_comb begin
		lock_next = lock_reg;
		reset_output_control_next = reset_output_control_reg;
		cdiv_next = wd_cdiv;
		cfg1_next = wd_cfg1;
		cfg2_next = wd_cfg2;
		variant_next = variant_reg;
		reload_cfg_next = reload_cfg_reg;
		// timestamp registers live outside and are never touched here
		if (word_load) begin
			case (idx_reg)
				reset_fault_pkg::IDX_PROTECT: lock_next = otp_data[reset_fault_pkg::PROTECT_BIT];
				reset_fault_pkg::IDX_RESET_OUTPUT_CONTROL: reset_output_control_next = otp_data[2:0];
				reset_fault_pkg::IDX_WDCDIV:  cdiv_next = otp_data;
				reset_fault_pkg::IDX_WDCFG1:  cfg1_next = otp_data;
				reset_fault_pkg::IDX_WDCFG2:  cfg2_next = otp_data;
				reset_fault_pkg::IDX_VARIANT: variant_next = otp_data;
				reset_fault_pkg::IDX_FAULT:   reload_cfg_next = otp_data[reset_fault_pkg::FLT_WDLOAD];
				default: ;
			endcase
		end else if (bus_wr_ok) begin
			case (reg_addr)
				reset_fault_pkg::ADDR_PROTECT: lock_next = reg_wdata[reset_fault_pkg::PROTECT_BIT];
				reset_fault_pkg::ADDR_RESET_OUTPUT_CONTROL: reset_output_control_next = reg_wdata[2:0];
				reset_fault_pkg::ADDR_WDCDIV:  if (!lock_reg) cdiv_next = reg_wdata;
				reset_fault_pkg::ADDR_WDCFG1:  if (!lock_reg) cfg1_next = reg_wdata;
				reset_fault_pkg::ADDR_WDCFG2:  if (!lock_reg) cfg2_next = reg_wdata;
				reset_fault_pkg::ADDR_FAULT:   reload_cfg_next = reg_wdata[reset_fault_pkg::FLT_WDLOAD];
				default: ;
			endcase
		end
	end

	// parity travels with every legitimate update, so only an upset can break it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lock_reg <= 1'b0;
			reset_output_control_reg <= reset_fault_pkg::RST_CFG[2:0];
			wd_cdiv <= reset_fault_pkg::RST_CFG;
			wd_cfg1 <= reset_fault_pkg::RST_CFG;
			wd_cfg2 <= reset_fault_pkg::RST_CFG;
			variant_reg <= reset_fault_pkg::RST_VARIANT;
			reload_cfg_reg <= 1'b0;
			parity_reg <= ^{reset_fault_pkg::RST_CFG[2:0], reset_fault_pkg::RST_CFG,
				reset_fault_pkg::RST_CFG, reset_fault_pkg::RST_CFG, reset_fault_pkg::RST_VARIANT};
		end else begin
			lock_reg <= lock_next;
			reset_output_control_reg <= reset_output_control_next;
			wd_cdiv <= cdiv_next;
			wd_cfg1 <= cfg1_next;
			wd_cfg2 <= cfg2_next;
			variant_reg <= variant_next;
			reload_cfg_reg <= reload_cfg_next;
			parity_reg <= ^{lock_next, reset_output_control_next, cdiv_next, cfg1_next, cfg2_next,
				variant_next, reload_cfg_next};
		end
	end
	assign parity_fault = parity_reg != ^{lock_reg, reset_output_control_reg, wd_cdiv, wd_cfg1, wd_cfg2,
		variant_reg, reload_cfg_reg};

	// configuration load sequencer
	assign take_run = ld_state_reg == reset_fault_pkg::LD_IDLE && (por_pend_reg || wd_pend_reg);
	assign take_en0 = ld_state_reg == reset_fault_pkg::LD_IDLE && !take_run && en0_pend_reg;
	assign load_busy = ld_state_reg == reset_fault_pkg::LD_RUN;
	assign word_load = load_busy && step_cnt_reg == 8'(reset_fault_pkg::WORD_CYC - 1);
	assign otp_index = idx_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			en0_d_reg <= 1'b0;
			por_pend_reg <= 1'b1;
			wd_pend_reg <= 1'b0;
			en0_pend_reg <= 1'b0;
		end else begin
			en0_d_reg <= en0_s;
			por_pend_reg <= por_pend_reg && !take_run;
			wd_pend_reg <= (wd_rst_reg && reload_cfg_reg) || (wd_pend_reg && !take_run);
			en0_pend_reg <= (en0_d_reg && !en0_s) || (en0_pend_reg && !take_en0);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ld_state_reg <= reset_fault_pkg::LD_IDLE;
			step_cnt_reg <= 8'h00;
			idx_reg <= 3'h0;
		end else begin
			case (ld_state_reg)
				reset_fault_pkg::LD_IDLE: begin
					step_cnt_reg <= 8'h00;
					idx_reg <= 3'h0;
					if (take_run)
						ld_state_reg <= reset_fault_pkg::LD_RUN;
					else if (take_en0)
						ld_state_reg <= reset_fault_pkg::LD_WAIT_REC;
				end
				reset_fault_pkg::LD_WAIT_REC: begin
					if (recorder_done)
						ld_state_reg <= reset_fault_pkg::LD_RUN;
				end
				reset_fault_pkg::LD_RUN: begin
					if (word_load) begin
						step_cnt_reg <= 8'h00;
						if (idx_reg == 3'(reset_fault_pkg::OTP_WORDS - 1))
							ld_state_reg <= reset_fault_pkg::LD_IDLE;
						else
							idx_reg <= idx_reg + 3'h1;
					end else begin
						step_cnt_reg <= step_cnt_reg + 8'h01;
					end
				end
				default: ld_state_reg <= reset_fault_pkg::LD_IDLE;
			endcase
		end
	end

	// reset pin: any cause pulls it low, hold timer runs once all are gone
	assign cause = (|ov_s) | (|uv_s) | (|off_s) | (|stuck_s) | uvlo_s
		| clk_fault_reg | parity_fault | wd_rst_reg;

	always_comb begin
		case (reset_output_control_reg[reset_fault_pkg::HOLD_LSB +: 2])
			2'b01:   hold_target = reset_fault_pkg::HOLD_W'(HOLD_8MS_CYC);
			2'b10:   hold_target = reset_fault_pkg::HOLD_W'(HOLD_16MS_CYC);
			2'b11:   hold_target = reset_fault_pkg::HOLD_W'(HOLD_32MS_CYC);
			default: hold_target = reset_fault_pkg::HOLD_W'(reset_fault_pkg::HOLD_MIN_CYC);
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rst_active_reg <= 1'b1;
			hold_cnt_reg <= '0;
		end else if (cause) begin
			rst_active_reg <= 1'b1;
			hold_cnt_reg <= '0;
		end else if (rst_active_reg) begin
			if (hold_cnt_reg >= hold_target - reset_fault_pkg::HOLD_W'(1))
				rst_active_reg <= 1'b0;
			else
				hold_cnt_reg <= hold_cnt_reg + reset_fault_pkg::HOLD_W'(1);
		end
	end
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe_n = !rst_active_reg;

	// register reads
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				reset_fault_pkg::ADDR_FAULT: reg_rdata <= {reload_cfg_reg, diag_flag_reg, bist_fail,
					rstpin_s, en1_s, en0_s, clk_fault_reg, parity_fault};
				reset_fault_pkg::ADDR_WDCDIV:  reg_rdata <= wd_cdiv;
				reset_fault_pkg::ADDR_WDCFG1:  reg_rdata <= wd_cfg1;
				reset_fault_pkg::ADDR_WDCFG2:  reg_rdata <= wd_cfg2;
				reset_fault_pkg::ADDR_PROTECT: reg_rdata <= {7'h00, lock_reg};
				reset_fault_pkg::ADDR_RESET_OUTPUT_CONTROL: reg_rdata <= {5'h00, reset_output_control_reg};
				reset_fault_pkg::ADDR_VARIANT: reg_rdata <= variant_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_protect;
		reg_wr && !load_busy && lock_reg && reg_addr == reset_fault_pkg::ADDR_WDCFG1
			|=> $stable(wd_cfg1);
	endproperty
	a_protect: assert property (p_protect) else $error("locked window register changed");
	property p_single;
		viol && !reset_output_control_reg[reset_fault_pkg::DBL_BIT] |=> wd_rst_reg ##1 !rst_pin_oe_n;
	endproperty
	a_single: assert property (p_single) else $error("single violation gave no reset");
	property p_double_first;
		viol && reset_output_control_reg[reset_fault_pkg::DBL_BIT] && !viol_cnt_reg |=> !wd_rst_reg && viol_cnt_reg;
	endproperty
	a_double_first: assert property (p_double_first) else $error("first violation reset");
	property p_hold_release;
		$fell(rst_active_reg) |-> $past(hold_cnt_reg) == $past(hold_target) - 22'h1;
	endproperty
	a_hold_release: assert property (p_hold_release) else $error("hold time wrong");
	property p_min_pulse;
		cause && reset_output_control_reg[1:0] == 2'b00 |=> !rst_pin_oe_n [*8];
	endproperty
	a_min_pulse: assert property (p_min_pulse) else $error("reset pulse too short");
	property p_variant_ro;
		reg_wr && !load_busy && reg_addr == reset_fault_pkg::ADDR_VARIANT |=> $stable(variant_reg);
	endproperty
	a_variant_ro: assert property (p_variant_ro) else $error("variant code written");
	property p_wait_rec;
		ld_state_reg == reset_fault_pkg::LD_WAIT_REC && !recorder_done |=> !load_busy;
	endproperty
	a_wait_rec: assert property (p_wait_rec) else $error("reload before recorder done");
	property p_wd_reload;
		wd_rst_reg && reload_cfg_reg && ld_state_reg == reset_fault_pkg::LD_IDLE && !en0_pend_reg
			|-> ##2 load_busy;
	endproperty
	a_wd_reload: assert property (p_wd_reload) else $error("no reload on watchdog fault");
	property p_reload_time;
		$rose(load_busy) |-> ##[118:120] $fell(load_busy);
	endproperty
	a_reload_time: assert property (p_reload_time) else $error("reload time wrong");
	property p_clock;
		clk_fault_reg |=> !rst_pin_oe_n;
	endproperty
	a_clock: assert property (p_clock) else $error("clock fault gave no reset");
	property p_diag;
		|stuck_s |=> diag_flag_reg && !rst_pin_oe_n;
	endproperty
	a_diag: assert property (p_diag) else $error("stuck comparator not flagged");
	property p_uvlo;
		uvlo_s |=> !rst_pin_oe_n && hold_cnt_reg == 22'h0;
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("lockout gave no reset");

	c_single: cover property (viol && !reset_output_control_reg[reset_fault_pkg::DBL_BIT] ##1 wd_rst_reg);
	c_double: cover property (viol && viol_cnt_reg && reset_output_control_reg[reset_fault_pkg::DBL_BIT]);
	c_reload: cover property ($fell(load_busy));
	c_release: cover property ($fell(rst_active_reg));
endmodule

// File: logic/reset_fault_pkg.sv
// constants, register map and state types for the reset and fault control block
// assumes one 125 MHz clock; all other files reach these by package::name
package reset_fault_pkg;

	localparam int CLK_MHZ = 125;

	// register offsets on the device register port
	localparam logic [7:0] ADDR_FAULT   = 8'h02;
	localparam logic [7:0] ADDR_WDCDIV  = 8'h27;
	localparam logic [7:0] ADDR_WDCFG1  = 8'h28;
	localparam logic [7:0] ADDR_WDCFG2  = 8'h29;
	localparam logic [7:0] ADDR_KEY     = 8'h2a;
	localparam logic [7:0] ADDR_PROTECT = 8'h2b;
	localparam logic [7:0] ADDR_RESET_OUTPUT_CONTROL = 8'h2c;
	localparam logic [7:0] ADDR_VARIANT = 8'h2d;

	// field positions
	localparam int PROTECT_BIT = 0;
	localparam int DBL_BIT     = 2;
	localparam int HOLD_LSB    = 0;
	localparam int FLT_PARITY  = 0;
	localparam int FLT_CLOCK   = 1;
	localparam int FLT_EN0     = 2;
	localparam int FLT_EN1     = 3;
	localparam int FLT_RSTPIN  = 4;
	localparam int FLT_BIST    = 5;
	localparam int FLT_DIAG    = 6;
	localparam int FLT_WDLOAD  = 7;

	// values after reset, before the first load from storage
	localparam logic [7:0] RST_CFG     = 8'h00;
	localparam logic [7:0] RST_VARIANT = 8'h5a; // arbitrary value

	// times and their cycle counts
	localparam int HOLD_MIN_NS   = 6000;
	localparam int HOLD_MIN_CYC  = HOLD_MIN_NS * CLK_MHZ / 1000;
	localparam int HOLD_8MS_MS   = 8;
	localparam int HOLD_16MS_MS  = 16;
	localparam int HOLD_32MS_MS  = 32;
	localparam int HOLD_8MS_CYC  = HOLD_8MS_MS * 1000 * CLK_MHZ;
	localparam int HOLD_16MS_CYC = HOLD_16MS_MS * 1000 * CLK_MHZ;
	localparam int HOLD_32MS_CYC = HOLD_32MS_MS * 1000 * CLK_MHZ;
	localparam int HOLD_W        = 22;
	localparam int RELOAD_NS     = 1000;
	localparam int RELOAD_CYC    = RELOAD_NS * CLK_MHZ / 1000;
	localparam int CLK_CHECK_NS  = 512;
	localparam int CLK_CHECK_CYC = CLK_CHECK_NS * CLK_MHZ / 1000;

	// storage word order for a configuration load
	localparam int OTP_WORDS = 7;
	localparam int WORD_CYC  = RELOAD_CYC / OTP_WORDS;
	localparam logic [2:0] IDX_PROTECT = 3'h0;
	localparam logic [2:0] IDX_RESET_OUTPUT_CONTROL = 3'h1;
	localparam logic [2:0] IDX_WDCDIV  = 3'h2;
	localparam logic [2:0] IDX_WDCFG1  = 3'h3;
	localparam logic [2:0] IDX_WDCFG2  = 3'h4;
	localparam logic [2:0] IDX_VARIANT = 3'h5;
	localparam logic [2:0] IDX_FAULT   = 3'h6;

	typedef enum logic [1:0] {LD_IDLE, LD_WAIT_REC, LD_RUN} load_state_t;

endpackage

// File: test/otp_store_model.sv
// storage model behind the configuration load port, answering combinationally
// assumes the 12-bit word layout has check bits at positions 1,2,4,8
module otp_store_model #(
	parameter int FLIP_WORD = 5, // word stored with one bit in error
	parameter int FLIP_BIT  = 6  // codeword bit that is flipped
) (
	input  wire logic [2:0]  otp_index, // word address from the block
	output logic      [11:0] otp_code   // encoded word
);
	// variant code 8'h3c is arbitrary
	localparam logic [7:0] WORDS [7] = '{8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h3c, 8'h00};

	function automatic logic [11:0] enc(input logic [7:0] d);
		logic [11:0] c;
		c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
		for (int p = 0; p < 4; p++) begin
			for (int k = 1; k <= 12; k++) begin
				if ((k & (1 << p)) != 0 && k != (1 << p)) begin
					c[(1 << p) - 1] = c[(1 << p) - 1] ^ c[k - 1];
				end
			end
		end
		return c;
	endfunction

	always_comb begin
		// index 7 holds no word: a fixed pattern rather than a stale value
		otp_code = (otp_index == 3'h7) ? 12'ha5a : enc(WORDS[otp_index]);
		if (otp_index == FLIP_WORD[2:0]) begin
			otp_code[FLIP_BIT] = ~otp_code[FLIP_BIT];
		end
	end
endmodule

// File: test/tb.sv
// self-checking bench for the reset and fault control block
// assumes the storage model above and a pulled-up reset pin
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, wd_early = 0, wd_expired = 0;
	logic        wd_refresh_ok = 0, uvlo = 0, bist_fail = 0, recorder_done = 1, en0_pin = 1;
	logic        en1_pin = 0, osc_mon_pin = 0, osc_run = 1;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, wd_cdiv, wd_cfg1, wd_cfg2, rd_val;
	logic [6:0]  rail_ov = '0, rail_uv = '0, rail_off = '0, comp_stuck = '0;
	logic        wd_key_wr, rst_pin_out, rst_pin_oe_n, load_busy;
	logic [2:0]  otp_index;
	logic [11:0] otp_code;
	wire logic   rst_pin_in = rst_pin_oe_n ? 1'b1 : rst_pin_out;
	int          errors = 0, checks = 0, n;
	localparam int HOLD [4] = '{750, 40, 80, 160};

	always #4 clk = ~clk;
	// system clock under check: 64 ns period, stopped only by the clock-fault test
	always #32 if (osc_run) osc_mon_pin = ~osc_mon_pin;

	reset_fault_control #(.HOLD_8MS_CYC(40), .HOLD_16MS_CYC(80), .HOLD_32MS_CYC(160)) i_dut (
		.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .wd_key_wr,
		.wd_cdiv, .wd_cfg1, .wd_cfg2, .wd_early, .wd_expired, .wd_refresh_ok, .rail_ov,
		.rail_uv, .rail_off, .comp_stuck, .uvlo, .bist_fail, .recorder_done, .en0_pin,
		.en1_pin, .osc_mon_pin, .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .otp_index,
		.otp_code, .load_busy);
	otp_store_model i_otp (.otp_index, .otp_code);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1; reg_addr = a; reg_wdata = d;
		@(negedge clk);
		reg_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		reg_rd = 1; reg_addr = a;
		@(negedge clk);
		reg_rd = 0; rd_val = reg_rdata;
	endtask
	task automatic wait_oe(input logic lvl, input int max);
		n = 0;
		while (rst_pin_oe_n !== lvl && n < max) begin
			@(negedge clk);
			n++;
		end
		if (rst_pin_oe_n !== lvl) begin
			errors++;
			$display("mismatch at %0t: reset pin wait timed out", $time);
		end
	endtask
	task automatic wait_busy(input logic lvl, input int max);
		n = 0;
		while (load_busy !== lvl && n < max) begin
			@(negedge clk);
			n++;
		end
		if (load_busy !== lvl) begin
			errors++;
			$display("mismatch at %0t: load wait timed out", $time);
		end
	endtask
	task automatic pulse(input int k);
		@(negedge clk);
		wd_expired = (k == 0); wd_early = (k == 1); wd_refresh_ok = (k == 2);
		@(negedge clk);
		wd_expired = 0; wd_early = 0; wd_refresh_ok = 0;
	endtask

	task automatic t_power_on;
		rd(reset_fault_pkg::ADDR_VARIANT);
		check(rd_val, 8'h3c, "variant after load");
		check(wd_cfg1, 8'h22, "window register loaded");
		check(wd_cdiv, 8'h11, "divider register loaded");
		check(wd_cfg2, 8'h33, "enable register loaded");
		wr(reset_fault_pkg::ADDR_VARIANT, 8'h00);
		rd(reset_fault_pkg::ADDR_VARIANT);
		check(rd_val, 8'h3c, "variant not writable");
		$display("test power_on done");
	endtask
	task automatic t_protect;
		wr(reset_fault_pkg::ADDR_PROTECT, 8'h01);
		wr(reset_fault_pkg::ADDR_WDCFG1, 8'h99);
		check(wd_cfg1, 8'h22, "protected write ignored");
		@(negedge clk);
		reg_wr = 1; reg_addr = reset_fault_pkg::ADDR_KEY;
		#1 check({7'h0, wd_key_wr}, 8'h01, "key write passes lock");
		@(negedge clk);
		reg_wr = 0;
		wr(reset_fault_pkg::ADDR_PROTECT, 8'h00);
		rd(reset_fault_pkg::ADDR_PROTECT);
		check(rd_val, 8'h00, "lock cleared while set");
		wr(reset_fault_pkg::ADDR_WDCFG1, 8'h99);
		check(wd_cfg1, 8'h99, "unlocked write taken");
		$display("test protect done");
	endtask
	task automatic t_hold;
		for (int c = 0; c < 4; c++) begin
			wr(reset_fault_pkg::ADDR_RESET_OUTPUT_CONTROL, 8'(c));
			pulse(c % 2);
			check({7'h0, rst_pin_oe_n}, 8'h01, "reset not yet low");
			cyc(1);
			check({7'h0, rst_pin_oe_n}, 8'h00, "violation asserts reset");
			check({7'h0, rst_pin_out}, 8'h00, "reset pin driven low");
			wait_oe(1, 1000);
			check({7'h0, n >= HOLD[c] - 3 && n <= HOLD[c] + 3}, 8'h01, "hold length");
		end
		$display("test hold done");
	endtask
	task automatic t_double;
		wr(reset_fault_pkg::ADDR_RESET_OUTPUT_CONTROL, 8'h05);
		pulse(0);
		cyc(5);
		check({7'h0, rst_pin_oe_n}, 8'h01, "first violation only counted");
		pulse(2);
		pulse(1);
		cyc(5);
		check({7'h0, rst_pin_oe_n}, 8'h01, "refresh cleared count");
		pulse(0);
		cyc(2);
		check({7'h0, rst_pin_oe_n}, 8'h00, "second violation resets");
		rd(reset_fault_pkg::ADDR_FAULT);
		check(rd_val & 8'h10, 8'h00, "reset pin reads low");
		wait_oe(1, 200);
		$display("test double done");
	endtask
	task automatic t_causes;
		wr(reset_fault_pkg::ADDR_RESET_OUTPUT_CONTROL, 8'h01);
		for (int k = 0; k < 6; k++) begin
			@(negedge clk);
			rail_ov[1] = (k == 0); rail_uv[3] = (k == 1); rail_off[6] = (k == 2);
			comp_stuck[0] = (k == 3); uvlo = (k == 4); osc_run = (k != 5);
			wait_oe(0, 100);
			check({7'h0, rst_pin_oe_n}, 8'h00, "cause asserts reset");
			rail_ov = '0; rail_uv = '0; rail_off = '0; comp_stuck = '0; uvlo = 0; osc_run = 1;
			wait_oe(1, 200);
			check({7'h0, n > 30}, 8'h01, "hold after cause cleared");
		end
		en1_pin = 1; en0_pin = 0; recorder_done = 0; bist_fail = 1;
		cyc(20);
		check({7'h0, load_busy}, 8'h00, "load waits for recorder");
		rd(reset_fault_pkg::ADDR_FAULT);
		check(rd_val, 8'h78, "comparator flag and pin levels");
		recorder_done = 1;
		wait_busy(1, 10);
		wait_busy(0, 300);
		check(8'(n), 8'h77, "load length");
		check(wd_cfg1, 8'h22, "window register restored");
		en0_pin = 1; en1_pin = 0; bist_fail = 0;
		$display("test causes done");
	endtask
	task automatic t_wd_reload;
		wr(reset_fault_pkg::ADDR_FAULT, 8'hc0);
		wr(reset_fault_pkg::ADDR_RESET_OUTPUT_CONTROL, 8'h02);
		pulse(0);
		wait_busy(1, 10);
		check({7'h0, load_busy}, 8'h01, "watchdog fault reloads");
		wait_busy(0, 300);
		rd(reset_fault_pkg::ADDR_RESET_OUTPUT_CONTROL);
		check(rd_val, 8'h00, "control restored");
		wait_oe(1, 1000);
		$display("test wd_reload done");
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		cyc(3);
		sys_rst = 0;
		wait_busy(0, 300);
		wait_oe(1, 2000);
		t_power_on();
		t_protect();
		t_hold();
		t_double();
		t_causes();
		t_wd_reload();
		end_of_test();
	end
	initial begin
		#400us;
		errors++;
		end_of_test();
	end
endmodule
